/* File: hdl/ucb_pkg.sv */
package ucb_pkg;

  // ==========================================================
  // bus carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ucb_apb_req_t;

  // ==========================================================
  // register offsets
  localparam logic [31:0] OFF_STATUS  = 32'h0000_0000;
  localparam logic [31:0] OFF_FORMAT  = 32'h0000_0004;
  localparam logic [31:0] OFF_ENABLE  = 32'h0000_0008;
  localparam logic [31:0] OFF_DIVISOR = 32'h0000_000C;
  localparam logic [31:0] OFF_DATA    = 32'h0000_0010;

  // ==========================================================
  // reset values
  localparam logic [7:0] FORMAT_RST  = 8'h00;
  localparam logic [7:0] ENABLE_RST  = 8'h00;
  localparam logic [7:0] DIVISOR_RST = 8'h00;

  // ==========================================================
  // format_control_reg fields
  localparam int FMT_GLOBAL_ON  = 7;
  localparam int FMT_NINTH_SEL  = 6;
  localparam int FMT_PARITY_ON  = 5;
  localparam int FMT_PARITY_ODD = 4;
  localparam int FMT_TWO_STOP   = 3;
  localparam int FMT_SEND_BREAK = 2;
  localparam int FMT_RX_NINE    = 1;
  localparam int FMT_TX_NINE    = 0;

  // ==========================================================
  // enable_irq_control_reg fields
  localparam int CTL_TX_ON      = 7;
  localparam int CTL_RX_ON      = 6;
  localparam int CTL_BAUD_FAST  = 5;
  localparam int CTL_ADDR_DET   = 4;
  localparam int CTL_WAKEUP_ON  = 3;
  localparam int CTL_RX_IRQ     = 2;
  localparam int CTL_TXIDLE_IRQ = 1;
  localparam int CTL_TXEMPT_IRQ = 0;

  // ==========================================================
  // status fields
  localparam int STAT_PARITY_ERR = 7;
  localparam int STAT_NOISE      = 6;
  localparam int STAT_FRAMING    = 5;
  localparam int STAT_OVERRUN    = 4;
  localparam int STAT_RX_IDLE    = 3;
  localparam int STAT_RX_AVAIL   = 2;
  localparam int STAT_TX_IDLE    = 1;
  localparam int STAT_TX_EMPTY   = 0;

  // ==========================================================
  // timing counts
  localparam logic [1:0] SLOW_PRE_LAST = 2'h3;  // 64 = 4 x 16
  localparam logic [3:0] OVS_LAST      = 4'hF;  // 16 ticks a bit
  localparam logic [3:0] SAMPLE_A      = 4'h7;
  localparam logic [3:0] SAMPLE_B      = 4'h8;
  localparam logic [3:0] SAMPLE_C      = 4'h9;
  localparam logic [3:0] BREAK_LAST    = 4'hC;  // 13 bit periods
  localparam logic [3:0] BASE_FRAME    = 4'hA;  // start, 8 data, stop

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_BREAK} ucb_tx_state_t;
  typedef enum logic {RX_IDLE, RX_BITS} ucb_rx_state_t;

endpackage

/* File: hdl/ucb_uart_ctrl.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - global off releases pins; on follows enables
// - disable empties buffer, resets baud counter
// - disable clears tx/rx enables and errors, sets idle flags
// - disable aborts transfers, clears send break; other config kept
// - ninth_bit_sel picks 8 or 9 bits
// - parity bit only while parity_on
// - parity_odd selects odd, else even
// - two_stop_sel gives two transmit stop bits
// - break low at least 13 bits
// - ninth bits in rx_bit_nine, tx_bit_nine
// - tx_on low aborts and releases transmitter
// - rx_on low aborts and releases receiver
// - baud is clock/64 or /16 times N+1
// - free-running 8-bit divisor timer
// - address word with bit set is kept
// - address detect discards words bit clear
// - rx falling edge wakes stopped clock
// - rx_irq_on gates receive request
// - tx_idle_irq_on gates idle request
// - tx_empty_irq_on gates empty request
// - NRZ, start bit, LSB first
// - receiver checks one stop bit
module ucb_uart_ctrl (
  input  logic                clk,       // system clock
  input  logic                rst_n,     // async reset
  input  ucb_pkg::ucb_apb_req_t apbReq,  // apb request
  output logic [31:0]         prdata,    // apb read data
  output logic                pready,    // apb ready
  output logic                pslverr,   // apb error
  input  logic                rxPin,     // serial input
  input  logic                fhStopped, // clock gated off
  output logic                txOut,     // serial output
  output logic                txPinOwn,  // uart owns tx pin
  output logic                rxPinOwn,  // uart owns rx pin
  output logic                irqReq,    // interrupt request
  output logic                wakeReq    // wake-up request
);
  import ucb_pkg::*;

  // ==========================================================
  // declarations
  logic [7:0]    fmt_reg;
  logic [7:0]    ctl_reg;
  logic [7:0]    divisor_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic          rxMeta_reg;
  logic          rxSync_reg;
  logic          rxPrev_reg;
  logic          stopMeta_reg;
  logic          stopSync_reg;
  logic [1:0]    preCnt_reg;
  logic [7:0]    baudCnt_reg;
  logic          ovsTick_reg;
  ucb_tx_state_t txState_reg;
  logic [3:0]    txPhase_reg;
  logic [12:0]   txShift_reg;
  logic [3:0]    txLeft_reg;
  logic [3:0]    brkCnt_reg;
  logic [8:0]    txBuf_reg;
  logic          txBufFull_reg;
  logic          txLine_reg;
  logic          txOwn_reg;
  ucb_rx_state_t rxState_reg;
  logic [3:0]    rxPhase_reg;
  logic [3:0]    rxIdx_reg;
  logic [10:0]   rxBits_reg;
  logic          sampA_reg;
  logic          sampB_reg;
  logic          rxNoiseAcc_reg;
  logic          rxDone_reg;
  logic          rxDoneFerr_reg;
  logic          rxOwn_reg;
  logic [8:0]    rxData_reg;
  logic          rxAvail_reg;
  logic          overrun_reg;
  logic          framingErr_reg;
  logic          parityErr_reg;
  logic          noise_reg;
  logic          txIdle_reg;
  logic          txEmpty_reg;
  logic          rxIdle_reg;
  logic          irq_reg;
  logic          wake_reg;
  logic          globalOn, ninthSel, parityOn, parityOdd;
  logic          twoStop, sendBreak, txActive, rxActive;
  logic          setupPh, accessPh, wrEn, mapped;
  logic          dataWr, dataRd, bitTick, rxFall, vote;
  logic [12:0]   txFrame;
  logic [3:0]    txLen;
  logic [3:0]    rxLen;
  logic [8:0]    rxWord;
  logic          rxParErr, rxDiscard, rxParBit, rxAddrBit;
  logic [7:0]    statusVal;

  assign globalOn  = fmt_reg[FMT_GLOBAL_ON];
  assign ninthSel  = fmt_reg[FMT_NINTH_SEL];
  assign parityOn  = fmt_reg[FMT_PARITY_ON];
  assign parityOdd = fmt_reg[FMT_PARITY_ODD];
  assign twoStop   = fmt_reg[FMT_TWO_STOP];
  assign sendBreak = fmt_reg[FMT_SEND_BREAK];
  assign txActive  = globalOn & ctl_reg[CTL_TX_ON];
  assign rxActive  = globalOn & ctl_reg[CTL_RX_ON];

  // ==========================================================
  // apb slave
  assign setupPh  = apbReq.psel & ~apbReq.penable;
  assign accessPh = apbReq.psel & apbReq.penable;
  assign wrEn     = accessPh & apbReq.pwrite & pready_reg;
  assign dataWr   = wrEn & (apbReq.paddr == OFF_DATA);
  assign dataRd   = accessPh & ~apbReq.pwrite & (apbReq.paddr == OFF_DATA);
  assign mapped   = (apbReq.paddr == OFF_STATUS) | (apbReq.paddr == OFF_FORMAT) |
                    (apbReq.paddr == OFF_ENABLE) | (apbReq.paddr == OFF_DIVISOR) |
                    (apbReq.paddr == OFF_DATA);

  assign statusVal = {parityErr_reg, noise_reg, framingErr_reg, overrun_reg,
                      rxIdle_reg, rxAvail_reg, txIdle_reg, txEmpty_reg};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setupPh) begin
        pslverr_reg <= ~mapped;
        unique case (apbReq.paddr)
          OFF_STATUS:  prdata_reg <= {24'h00_0000, statusVal};
          // tx_bit_nine is write-only, reads zero
          OFF_FORMAT:  prdata_reg <= {24'h00_0000, fmt_reg[7:2], rxData_reg[8], 1'b0};
          OFF_ENABLE:  prdata_reg <= {24'h00_0000, ctl_reg};
          OFF_DIVISOR: prdata_reg <= {24'h00_0000, divisor_reg};
          OFF_DATA:    prdata_reg <= {24'h00_0000, rxData_reg[7:0]};
          default:     prdata_reg <= 32'h0000_0000;
        endcase
      end else if (!accessPh) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_reg     <= FORMAT_RST;
      ctl_reg     <= ENABLE_RST;
      divisor_reg <= DIVISOR_RST;
    end else begin
      if (!globalOn) begin
        ctl_reg[CTL_TX_ON]      <= 1'b0;
        ctl_reg[CTL_RX_ON]      <= 1'b0;
        fmt_reg[FMT_SEND_BREAK] <= 1'b0;
      end
      if (wrEn && apbReq.paddr == OFF_FORMAT) begin
        fmt_reg[7:2]         <= apbReq.pwdata[7:2];
        fmt_reg[FMT_TX_NINE] <= apbReq.pwdata[FMT_TX_NINE];
      end
      if (wrEn && apbReq.paddr == OFF_ENABLE) begin
        ctl_reg <= apbReq.pwdata[7:0];
      end
      if (wrEn && apbReq.paddr == OFF_DIVISOR) begin
        divisor_reg <= apbReq.pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // input synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta_reg   <= 1'b1;
      rxSync_reg   <= 1'b1;
      rxPrev_reg   <= 1'b1;
      stopMeta_reg <= 1'b0;
      stopSync_reg <= 1'b0;
    end else begin
      rxMeta_reg   <= rxPin;
      rxSync_reg   <= rxMeta_reg;
      rxPrev_reg   <= rxSync_reg;
      stopMeta_reg <= fhStopped;
      stopSync_reg <= stopMeta_reg;
    end
  end

  assign rxFall = rxPrev_reg & ~rxSync_reg;

  // ==========================================================
  // baud generator: prescale 4 or 1, then N+1, then 16 per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_reg  <= 2'h0;
      baudCnt_reg <= 8'h00;
      ovsTick_reg <= 1'b0;
    end else if (!globalOn) begin
      preCnt_reg  <= 2'h0;
      baudCnt_reg <= 8'h00;
      ovsTick_reg <= 1'b0;
    end else begin
      ovsTick_reg <= 1'b0;
      if (ctl_reg[CTL_BAUD_FAST] || preCnt_reg == SLOW_PRE_LAST) begin
        preCnt_reg <= 2'h0;
        if (baudCnt_reg == 8'h00) begin
          baudCnt_reg <= divisor_reg;
          ovsTick_reg <= 1'b1;
        end else begin
          baudCnt_reg <= baudCnt_reg - 8'h01;
        end
      end else begin
        preCnt_reg <= preCnt_reg + 2'h1;
      end
    end
  end

  assign bitTick = ovsTick_reg & (txPhase_reg == OVS_LAST);

  // ==========================================================
  // transmit frame assembly
  always_comb begin
    txFrame    = 13'h1FFF;
    txFrame[0] = 1'b0;
    txFrame[8:1] = txBuf_reg[7:0];
    if (ninthSel) begin
      txFrame[9] = txBuf_reg[8];
      if (parityOn) begin
        txFrame[10] = ^txBuf_reg ^ parityOdd;
      end
    end else if (parityOn) begin
      txFrame[9] = ^txBuf_reg[7:0] ^ parityOdd;
    end
    txLen = BASE_FRAME + {3'h0, ninthSel} + {3'h0, parityOn} + {3'h0, twoStop};
  end

  // ==========================================================
  // transmitter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_reg   <= TX_IDLE;
      txPhase_reg   <= 4'h0;
      txShift_reg   <= 13'h1FFF;
      txLeft_reg    <= 4'h0;
      brkCnt_reg    <= 4'h0;
      txBuf_reg     <= 9'h000;
      txBufFull_reg <= 1'b0;
      txLine_reg    <= 1'b1;
    end else if (!txActive) begin
      txState_reg   <= TX_IDLE;
      txPhase_reg   <= 4'h0;
      txLeft_reg    <= 4'h0;
      brkCnt_reg    <= 4'h0;
      txBufFull_reg <= 1'b0;
      txLine_reg    <= 1'b1;
    end else begin
      if (ovsTick_reg) begin
        txPhase_reg <= txPhase_reg + 4'h1;
      end
      if (dataWr) begin
        txBuf_reg     <= {fmt_reg[FMT_TX_NINE], apbReq.pwdata[7:0]};
        txBufFull_reg <= 1'b1;
      end
      if (bitTick) begin
        unique case (txState_reg)
          TX_IDLE, TX_SEND: begin
            if (txState_reg == TX_SEND && txLeft_reg != 4'h0) begin
              txLine_reg  <= txShift_reg[0];
              txShift_reg <= {1'b1, txShift_reg[12:1]};
              txLeft_reg  <= txLeft_reg - 4'h1;
            end else if (txBufFull_reg && !dataWr) begin
              txState_reg   <= TX_SEND;
              txLine_reg    <= txFrame[0];
              txShift_reg   <= {1'b1, txFrame[12:1]};
              txLeft_reg    <= txLen - 4'h1;
              txBufFull_reg <= 1'b0;
            end else if (sendBreak) begin
              txState_reg <= TX_BREAK;
              txLine_reg  <= 1'b0;
              brkCnt_reg  <= 4'h0;
            end else begin
              txState_reg <= TX_IDLE;
              txLine_reg  <= 1'b1;
            end
          end
          TX_BREAK: begin
            if (brkCnt_reg != BREAK_LAST) begin
              brkCnt_reg <= brkCnt_reg + 4'h1;
            end else if (!sendBreak) begin
              txState_reg <= TX_IDLE;
              txLine_reg  <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // receive word decode
  always_comb begin
    rxLen     = 4'h9 + {3'h0, ninthSel} + {3'h0, parityOn};
    rxWord    = ninthSel ? rxBits_reg[8:0] : {1'b0, rxBits_reg[7:0]};
    rxParBit  = ninthSel ? rxBits_reg[9] : rxBits_reg[8];
    rxParErr  = parityOn & (rxParBit != (^rxWord ^ parityOdd));
    rxAddrBit = ninthSel ? rxBits_reg[8] : rxBits_reg[7];
    rxDiscard = ctl_reg[CTL_ADDR_DET] & ~rxAddrBit;
  end

  assign vote = (sampA_reg & sampB_reg) | (sampA_reg & rxSync_reg) |
                (sampB_reg & rxSync_reg);

  // ==========================================================
  // receiver
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_reg    <= RX_IDLE;
      rxPhase_reg    <= 4'h0;
      rxIdx_reg      <= 4'h0;
      rxBits_reg     <= 11'h000;
      sampA_reg      <= 1'b1;
      sampB_reg      <= 1'b1;
      rxNoiseAcc_reg <= 1'b0;
      rxDone_reg     <= 1'b0;
      rxDoneFerr_reg <= 1'b0;
    end else if (!rxActive) begin
      rxState_reg <= RX_IDLE;
      rxDone_reg  <= 1'b0;
    end else begin
      rxDone_reg <= 1'b0;
      unique case (rxState_reg)
        RX_IDLE: begin
          if (rxFall) begin
            rxState_reg    <= RX_BITS;
            rxPhase_reg    <= 4'h0;
            rxIdx_reg      <= 4'h0;
            rxNoiseAcc_reg <= 1'b0;
          end
        end
        RX_BITS: begin
          if (ovsTick_reg) begin
            rxPhase_reg <= rxPhase_reg + 4'h1;
            if (rxPhase_reg == OVS_LAST) begin
              rxIdx_reg <= rxIdx_reg + 4'h1;
            end
            if (rxPhase_reg == SAMPLE_A) begin
              sampA_reg <= rxSync_reg;
            end
            if (rxPhase_reg == SAMPLE_B) begin
              sampB_reg <= rxSync_reg;
            end
            if (rxPhase_reg == SAMPLE_C) begin
              if (sampA_reg != sampB_reg || sampB_reg != rxSync_reg) begin
                rxNoiseAcc_reg <= 1'b1;
              end
              if (rxIdx_reg == 4'h0 && vote) begin
                rxState_reg <= RX_IDLE;
              end else if (rxIdx_reg == rxLen) begin
                rxState_reg    <= RX_IDLE;
                rxDone_reg     <= 1'b1;
                rxDoneFerr_reg <= ~vote;
              end else if (rxIdx_reg != 4'h0) begin
                rxBits_reg[rxIdx_reg - 4'h1] <= vote;
              end
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // receive holding register and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxData_reg     <= 9'h000;
      rxAvail_reg    <= 1'b0;
      overrun_reg    <= 1'b0;
      framingErr_reg <= 1'b0;
      parityErr_reg  <= 1'b0;
      noise_reg      <= 1'b0;
    end else if (!rxActive) begin
      rxAvail_reg    <= 1'b0;
      overrun_reg    <= 1'b0;
      framingErr_reg <= 1'b0;
      parityErr_reg  <= 1'b0;
      noise_reg      <= 1'b0;
    end else begin
      if (dataRd) begin
        rxAvail_reg    <= 1'b0;
        overrun_reg    <= 1'b0;
        framingErr_reg <= 1'b0;
        parityErr_reg  <= 1'b0;
        noise_reg      <= 1'b0;
      end
      // new word wins over a clearing read
      if (rxDone_reg && !rxDiscard) begin
        if (rxAvail_reg && !dataRd) begin
          overrun_reg <= 1'b1;
        end else begin
          rxData_reg     <= rxWord;
          rxAvail_reg    <= 1'b1;
          framingErr_reg <= rxDoneFerr_reg;
          parityErr_reg  <= rxParErr;
          noise_reg      <= rxNoiseAcc_reg;
        end
      end
    end
  end

  // ==========================================================
  // status, pins, requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txIdle_reg  <= 1'b1;
      txEmpty_reg <= 1'b1;
      rxIdle_reg  <= 1'b1;
      txOwn_reg   <= 1'b0;
      rxOwn_reg   <= 1'b0;
      irq_reg     <= 1'b0;
      wake_reg    <= 1'b0;
    end else begin
      txEmpty_reg <= ~txBufFull_reg | ~txActive;
      txIdle_reg  <= ~txActive | (~txBufFull_reg & (txState_reg == TX_IDLE) & ~sendBreak);
      rxIdle_reg  <= ~rxActive | (rxState_reg == RX_IDLE);
      txOwn_reg   <= txActive;
      rxOwn_reg   <= rxActive;
      if (!stopSync_reg || !globalOn || !ctl_reg[CTL_WAKEUP_ON]) begin
        wake_reg <= 1'b0;
      end else if (rxFall) begin
        wake_reg <= 1'b1;
      end
      irq_reg <= (ctl_reg[CTL_RX_IRQ] & (rxAvail_reg | overrun_reg)) |
                 (ctl_reg[CTL_TXIDLE_IRQ] & txIdle_reg) |
                 (ctl_reg[CTL_TXEMPT_IRQ] & txEmpty_reg) |
                 wake_reg;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign txOut    = txLine_reg;
  assign txPinOwn = txOwn_reg;
  assign rxPinOwn = rxOwn_reg;
  assign irqReq   = irq_reg;
  assign wakeReq  = wake_reg;

endmodule

/* File: tb/ucb_uart_ctrl_assertions.sv */
`timescale 1ns/1ps
module ucb_uart_ctrl_assertions (
  input logic                  clk,       // clock
  input logic                  rst_n,     // reset
  input ucb_pkg::ucb_apb_req_t apbReq,    // apb request
  input logic [31:0]           prdata,    // read data
  input logic                  pready,    // ready
  input logic                  pslverr,   // error
  input logic                  rxPin,     // serial in
  input logic                  fhStopped, // clock stopped
  input logic                  txOut,     // serial out
  input logic                  txPinOwn,  // tx pin owned
  input logic                  rxPinOwn,  // rx pin owned
  input logic                  irqReq,    // interrupt
  input logic                  wakeReq    // wake request
);
  import ucb_pkg::*;
  // ==========
  // helpers
  logic        wrCyc;
  logic        wrFmt;
  logic        wrCtl;
  logic [11:0] lowRun;
  assign wrCyc = apbReq.psel && apbReq.penable && apbReq.pwrite && pready;
  assign wrFmt = wrCyc && apbReq.paddr == OFF_FORMAT;
  assign wrCtl = wrCyc && apbReq.paddr == OFF_ENABLE;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowRun <= 12'h000;
    end else if (txOut) begin
      lowRun <= 12'h000;
    end else if (lowRun != 12'hFFF) begin
      lowRun <= lowRun + 12'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // properties
  chk_global_off_pins: assert property (
    wrFmt && !apbReq.pwdata[FMT_GLOBAL_ON] |=> ##[0:1] !txPinOwn && !rxPinOwn)
    else $error("pins owned after global off");
  chk_tx_off_pin: assert property (
    wrCtl && !apbReq.pwdata[CTL_TX_ON] |=> ##[0:1] !txPinOwn)
    else $error("tx pin owned after tx off");
  chk_rx_off_pin: assert property (
    wrCtl && !apbReq.pwdata[CTL_RX_ON] |=> ##[0:1] !rxPinOwn)
    else $error("rx pin owned after rx off");
  chk_tx_idle_high: assert property (
    !txPinOwn && !$past(txPinOwn) |-> txOut)
    else $error("tx low while transmitter off");
  chk_abort_release: assert property (
    $fell(txPinOwn) |-> ##[0:1] txOut)
    else $error("tx not released on abort");
  chk_bit_min_len: assert property (
    $rose(txOut) && txPinOwn |-> lowRun >= 12'h010)
    else $error("low run shorter than one bit");
  chk_wake_gate: assert property (
    $rose(wakeReq) |-> $past(fhStopped, 2) || $past(fhStopped, 3) || $past(fhStopped, 4))
    else $error("wake while clock running");
  chk_irq_gate: assert property (
    wrCtl && apbReq.pwdata[3:0] == 4'h0 |-> ##3 (!irqReq || wakeReq))
    else $error("irq with sources masked");
endmodule

bind ucb_uart_ctrl ucb_uart_ctrl_assertions ucb_uart_ctrl_assertions_i (
  .clk(clk), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxPin(rxPin), .fhStopped(fhStopped), .txOut(txOut),
  .txPinOwn(txPinOwn), .rxPinOwn(rxPinOwn), .irqReq(irqReq), .wakeReq(wakeReq)
);

/* File: tb/ucb_serial_peer.sv */
`timescale 1ns/1ps
module ucb_serial_peer (
  input  logic clk,   // system clock
  input  logic txOut, // line from uart
  output logic rxLine // line to uart
);
  int bitClks;
  initial begin
    bitClks = 32;
    rxLine = 1'b1;
  end
  // ==========
  // frame to uart, line idles high
  task automatic send(input logic [11:0] bits, input int n);
    rxLine <= 1'b0;
    repeat (bitClks) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxLine <= bits[i];
      repeat (bitClks) @(posedge clk);
    end
    rxLine <= 1'b1;
    repeat (bitClks) @(posedge clk);
  endtask
  // ==========
  // frame from uart, sampled mid-bit
  task automatic recv(output logic [11:0] bits, output logic ok);
    int t;
    bits = 12'h000;
    for (t = 0; t < 4000 && txOut; t++) @(negedge clk);
    ok = !txOut;
    repeat (bitClks / 2) @(negedge clk);
    for (int i = 0; i < 12; i++) begin
      repeat (bitClks) @(negedge clk);
      bits[i] = txOut;
    end
  endtask
endmodule

/* File: tb/ucb_uart_ctrl_bench.sv */
`timescale 1ns/1ps
module ucb_uart_ctrl_bench;
  import ucb_pkg::*;
  localparam logic [3:0] TXCFG [6] = '{4'h0, 4'h1, 4'h6, 4'hC, 4'hB, 4'h0};
  logic         clk;
  logic         rst_n;
  ucb_apb_req_t apbReq;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         rxPin;
  logic         fhStopped;
  logic         txOut;
  logic         txPinOwn;
  logic         rxPinOwn;
  logic         irqReq;
  logic         wakeReq;
  int           nMismatch;
  int           totalChecks;
  int           cnt;
  logic [31:0]  rdv;
  logic [11:0]  bits;
  logic [3:0]   cfg;
  logic         ok;
  logic         err;
  ucb_uart_ctrl ucb_uart_ctrl_i (
    .clk(clk), .rst_n(rst_n), .apbReq(apbReq), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxPin(rxPin), .fhStopped(fhStopped), .txOut(txOut),
    .txPinOwn(txPinOwn), .rxPinOwn(rxPinOwn), .irqReq(irqReq), .wakeReq(wakeReq)
  );
  ucb_serial_peer ucb_serial_peer_i (.clk(clk), .txOut(txOut), .rxLine(rxPin));
  // ==========
  // helpers
  task automatic endSim;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (t = 0; t < 16; t++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rdv = prdata;
    err = pslverr;
    apbReq <= '0;
    if (t == 16) begin
      nMismatch++;
      endSim();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rdv, exp);
  endtask
  // expected line bits after the start bit
  function automatic logic [11:0] frame(logic [8:0] d, logic [3:0] c, logic nxt);
    int n;
    logic p;
    logic [11:0] f;
    n = c[3] ? 9 : 8;
    p = c[1];
    f = 12'hFFF;
    for (int i = 0; i < n; i++) begin
      f[i] = d[i];
      p = p ^ d[i];
    end
    if (c[2]) f[n] = p;
    n = n + c[2] + (c[0] ? 2 : 1);
    for (int i = n; i < 12; i++) f[i] = !nxt;
    return f;
  endfunction
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========
  // main sequence
  initial begin
    rst_n = 1'b0;
    apbReq = '0;
    fhStopped = 1'b0;
    nMismatch = 0;
    totalChecks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_STATUS, 32'h0B, "status");
    rd(OFF_FORMAT, 32'h00, "format");
    rd(OFF_ENABLE, 32'h00, "enable");
    rd(32'h14, 32'h00, "unmapped");
    check("slverr", {31'h0, err}, 32'h1);
    wr(OFF_DIVISOR, 32'hFF);
    rd(OFF_DIVISOR, 32'hFF, "divisor");
    wr(OFF_DIVISOR, 32'h01);
    for (int k = 0; k < 6; k++) begin
      cfg = TXCFG[k];
      ucb_serial_peer_i.bitClks = (k == 5) ? 128 : 32;
      wr(OFF_FORMAT, {24'h0, 1'b1, cfg, 3'h1});
      wr(OFF_ENABLE, (k == 5) ? 32'hC0 : 32'hE0);
      rd(OFF_FORMAT, {24'h0, 1'b1, cfg, 3'h0}, "tx nine");
      fork
        ucb_serial_peer_i.recv(bits, ok);
        begin
          wr(OFF_DATA, 32'h5A);
          repeat (2 * ucb_serial_peer_i.bitClks) @(posedge clk);
          wr(OFF_DATA, 32'h00);
        end
      join
      check("tx", {19'h0, ok, bits}, {19'h1, frame(9'h15A, cfg, 1'b1)});
      repeat (16 * ucb_serial_peer_i.bitClks) @(posedge clk);
    end
    ucb_serial_peer_i.bitClks = 32;
    wr(OFF_ENABLE, 32'hE4);
    for (int k = 0; k < 2; k++) begin
      cfg = k ? 4'h6 : 4'hD;
      wr(OFF_FORMAT, {24'h0, 1'b1, cfg, 3'h0});
      bits = frame(9'h1A5, cfg, 1'b0);
      bits[cfg[3] ? 9 : 8] ^= k[0];
      bits[9] ^= k[0];
      ucb_serial_peer_i.send(bits, cfg[3] ? 11 : 10);
      check("rx irq", {31'h0, irqReq}, 32'h1);
      rd(OFF_STATUS, k ? 32'hAF : 32'h0F, "rx status");
      if (k == 0) rd(OFF_FORMAT, 32'hEA, "rx nine");
      rd(OFF_DATA, 32'hA5, "rx data");
      repeat (2) @(posedge clk);
      check("rx irq off", {31'h0, irqReq}, 32'h0);
    end
    wr(OFF_FORMAT, 32'h80);
    wr(OFF_ENABLE, 32'hF4);
    for (int k = 0; k < 2; k++) begin
      ucb_serial_peer_i.send({3'h7, 1'b1, k[0], 7'h35}, 9);
      check("addr irq", {31'h0, irqReq}, k);
      rd(OFF_STATUS, k ? 32'h0F : 32'h0B, "addr status");
      if (k == 1) rd(OFF_DATA, 32'hB5, "addr data");
    end
    for (int k = 0; k < 4; k++) begin
      wr(OFF_ENABLE, 32'hE0 | (32'h1 << k));
      repeat (3) @(posedge clk);
      check("irq src", {31'h0, irqReq}, k < 2);
    end
    wr(OFF_FORMAT, 32'h84);
    for (cnt = 0; cnt < 100 && txOut; cnt++) @(negedge clk);
    fork
      for (cnt = 0; cnt < 2000 && !txOut; cnt++) @(negedge clk);
      wr(OFF_FORMAT, 32'h80);
    join
    check("break", {31'h0, cnt >= 415 && cnt < 2000}, 32'h1);
    wr(OFF_ENABLE, 32'hE4);
    wr(OFF_FORMAT, 32'hA8);
    wr(OFF_DATA, 32'h77);
    repeat (100) @(posedge clk);
    wr(OFF_ENABLE, 32'h64);
    repeat (2) @(posedge clk);
    check("tx off", {30'h0, txOut, txPinOwn}, 32'h2);
    wr(OFF_ENABLE, 32'hA4);
    repeat (2) @(posedge clk);
    check("rx off", {31'h0, rxPinOwn}, 32'h0);
    wr(OFF_ENABLE, 32'hE4);
    ucb_serial_peer_i.send(12'hFFF, 10);
    rd(OFF_STATUS, 32'h8F, "pre off");
    wr(OFF_DATA, 32'h77);
    repeat (100) @(posedge clk);
    wr(OFF_FORMAT, 32'h28);
    repeat (2) @(posedge clk);
    check("off pins", {29'h0, txOut, txPinOwn, rxPinOwn}, 32'h4);
    rd(OFF_ENABLE, 32'h24, "off enable");
    rd(OFF_STATUS, 32'h0B, "off status");
    rd(OFF_FORMAT, 32'h28, "off format");
    rd(OFF_DIVISOR, 32'h01, "off divisor");
    wr(OFF_FORMAT, 32'hA8);
    wr(OFF_ENABLE, 32'hE4);
    fork
      ucb_serial_peer_i.recv(bits, ok);
      wr(OFF_DATA, 32'h3C);
    join
    check("resume", {19'h0, ok, bits}, {19'h1, frame(9'h03C, 4'h5, 1'b0)});
    repeat (16 * 32) @(posedge clk);
    wr(OFF_FORMAT, 32'h80);
    wr(OFF_ENABLE, 32'h08);
    for (int k = 0; k < 2; k++) begin
      fhStopped <= k[0];
      repeat (4) @(posedge clk);
      ucb_serial_peer_i.send(12'hFFF, 1);
      check("wake", {30'h0, wakeReq, irqReq}, k ? 32'h3 : 32'h0);
    end
    endSim();
  end
endmodule
